/* src/lane_map_pkg.sv */
// Constants for the lane sample mapper
package lane_map_pkg;
	localparam int SAMPLE_W = 9;
	localparam int LANES = 8;
	localparam int CHANNELS = 4;
	// Lane word: widest frame is eight octets (format 11)
	localparam int FRAME_W = 64;
	localparam int SAMPLES_MAX = 20;
	localparam int FMT_W = 4;
	localparam logic [3:0] FMT_5 = 4'h5;
	localparam logic [3:0] FMT_6 = 4'h6;
	localparam logic [3:0] FMT_7 = 4'h7;
	localparam logic [3:0] FMT_8 = 4'h8;
	localparam logic [3:0] FMT_9 = 4'h9;
	localparam logic [3:0] FMT_10 = 4'hA;
	localparam logic [3:0] FMT_11 = 4'hB;
	localparam logic [1:0] VAR_SINGLE = 2'h0;
	localparam logic [1:0] VAR_DUAL = 2'h1;
	localparam logic [1:0] VAR_QUAD = 2'h2;
	localparam logic [2:0] PAD3 = 3'h0;
	localparam logic PAD1 = 1'h0;
	localparam logic [7:0] FILL_OCTET = 8'h00;
	localparam logic [3:0] TAIL_DEFAULT = 4'h0;
endpackage

/* src/lane_enable_decode.sv */
// Active-lane mask from format and channel variant
`timescale 1ns/1ps
module lane_enable_decode
	import lane_map_pkg::*;
(
	input wire logic [FMT_W-1:0] fmt,
	input wire logic [1:0] variant,
	output logic [LANES-1:0] lane_en
);
	always_comb begin
		lane_en = '0;
		case (fmt)
			FMT_5: lane_en = (variant == VAR_QUAD) ? 8'h03 : 8'h01;
			FMT_6: lane_en = (variant == VAR_QUAD) ? 8'h3F :
				(variant == VAR_DUAL) ? 8'h07 : 8'h03;
			FMT_7, FMT_8: lane_en = (variant == VAR_QUAD) ? 8'h0F :
				(variant == VAR_DUAL) ? 8'h03 : 8'h01;
			FMT_9, FMT_10: lane_en = (variant == VAR_QUAD) ? 8'hFF :
				(variant == VAR_DUAL) ? 8'h0F : 8'h03;
			// Quad and the spare variant code get no lanes here
			FMT_11: lane_en = (variant == VAR_DUAL) ? 8'hFF :
				(variant == VAR_SINGLE) ? 8'h0F : 8'h00;
			default: lane_en = '0;
		endcase
	end
endmodule

/* src/lane_sample_mapper.sv */
// Transport mapper placing channel samples onto serial lane frames
// ==========================================================
`timescale 1ns/1ps
module lane_sample_mapper
	import lane_map_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [lane_map_pkg::FMT_W-1:0] link_format_select,
	input wire logic [1:0] variant,
	input wire logic [3:0] tail_fill,
	input wire logic frame_valid,
	input wire logic [lane_map_pkg::CHANNELS*lane_map_pkg::SAMPLES_MAX*lane_map_pkg::SAMPLE_W-1:0] samples,
	output logic frame_out_valid,
	output logic [lane_map_pkg::LANES-1:0] lane_active,
	output logic [lane_map_pkg::FRAME_W-1:0] serial_lane_0,
	output logic [lane_map_pkg::FRAME_W-1:0] serial_lane_1,
	output logic [lane_map_pkg::FRAME_W-1:0] serial_lane_2,
	output logic [lane_map_pkg::FRAME_W-1:0] serial_lane_3,
	output logic [lane_map_pkg::FRAME_W-1:0] serial_lane_4,
	output logic [lane_map_pkg::FRAME_W-1:0] serial_lane_5,
	output logic [lane_map_pkg::FRAME_W-1:0] serial_lane_6,
	output logic [lane_map_pkg::FRAME_W-1:0] serial_lane_7
);
	import lane_map_pkg::*;

	typedef logic [FRAME_W-1:0] word_t;

	// Sample n of channel c (c: 0=A..3=D)
	function automatic logic [SAMPLE_W-1:0] smp(input int c, input int n);
		smp = samples[(c*SAMPLES_MAX+n)*SAMPLE_W +: SAMPLE_W];
	endfunction
	function automatic logic [11:0] f12(input int c, input int n);
		f12 = {smp(c, n), PAD3};
	endfunction
	function automatic logic [9:0] f10(input int c, input int n);
		f10 = {smp(c, n), PAD1};
	endfunction
	// Top octet of a sample; 8-bit formats drop the LSB
	function automatic logic [7:0] oct8(input int c, input int n);
		logic [SAMPLE_W-1:0] s;
		s = smp(c, n);
		oct8 = s[SAMPLE_W-1 -: 8];
	endfunction

	logic [LANES-1:0] en;
	word_t lane_nxt [LANES];
	word_t lane_r [LANES];
	logic valid_r;
	logic multi;

	lane_enable_decode u_dec (
		.fmt(link_format_select),
		.variant(variant),
		.lane_en(en)
	);

	assign multi = (variant != VAR_SINGLE);

	// Field packing below is written for 9-bit samples in 64-bit words on eight lanes
	if (FRAME_W != 64 || LANES != 8 || SAMPLE_W != 9) begin : g_size_check
		$error("lane word geometry unsupported");
	end

	// ==========================================================
	// Mapping (words left-justified: nibble 0 is bits 63:60)
	always_comb begin
		logic [47:0] f6;
		logic [7:0] b_oct;
		f6 = '0;
		b_oct = '0;
		for (int l = 0; l < LANES; l++) begin
			lane_nxt[l] = '0;
		end
		case (link_format_select)
			FMT_5: begin
				b_oct = multi ? oct8(1, 0) : FILL_OCTET;
				lane_nxt[0] = {oct8(0, 0), b_oct, 48'h0};
				lane_nxt[1] = {oct8(2, 0), oct8(3, 0), 48'h0};
			end
			FMT_6: begin
				for (int p = 0; p < 2; p++) begin
					f6 = {f12(2*p, 0), f12(2*p, 1), f12(2*p+1, 0), f12(2*p+1, 1)};
					if (p == 0 && !multi)
						f6[23:16] = FILL_OCTET;
					lane_nxt[3*p] = {f6[47:32], 48'h0};
					lane_nxt[3*p+1] = {f6[31:16], 48'h0};
					lane_nxt[3*p+2] = {f6[15:0], 48'h0};
				end
			end
			FMT_7: begin
				for (int l = 0; l < 4; l++)
					lane_nxt[l] = {oct8(l, 0), 56'h0};
			end
			FMT_8: begin
				for (int l = 0; l < 4; l++)
					lane_nxt[l] = {f12(l, 0), f12(l, 1), 40'h0};
			end
			FMT_9: begin
				for (int l = 0; l < LANES; l++)
					lane_nxt[l] = {oct8(l/2, l%2), 56'h0};
			end
			FMT_10: begin
				for (int l = 0; l < LANES; l++)
					lane_nxt[l] = {f10(l/2, l%2), f10(l/2, l%2+2), f10(l/2, l%2+4),
						f10(l/2, l%2+6), 24'h0};
			end
			FMT_11: begin
				if (variant != VAR_QUAD) begin
					for (int l = 0; l < LANES; l++)
						lane_nxt[l] = {f12(l/4, l%4), f12(l/4, l%4+4), f12(l/4, l%4+8),
							f12(l/4, l%4+12), f12(l/4, l%4+16), tail_fill};
				end
			end
			default: ;
		endcase
		for (int l = 0; l < LANES; l++) begin
			if (!en[l])
				lane_nxt[l] = '0;
		end
	end

	// ==========================================================
	// Output registers
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			for (int l = 0; l < LANES; l++)
				lane_r[l] <= '0;
		end else if (frame_valid) begin
			for (int l = 0; l < LANES; l++)
				lane_r[l] <= lane_nxt[l];
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			valid_r <= 1'b0;
			lane_active <= '0;
		end else begin
			valid_r <= frame_valid;
			lane_active <= en;
		end
	end

	assign frame_out_valid = valid_r;
	assign serial_lane_0 = lane_r[0];
	assign serial_lane_1 = lane_r[1];
	assign serial_lane_2 = lane_r[2];
	assign serial_lane_3 = lane_r[3];
	assign serial_lane_4 = lane_r[4];
	assign serial_lane_5 = lane_r[5];
	assign serial_lane_6 = lane_r[6];
	assign serial_lane_7 = lane_r[7];

	// ==========================================================
	// Assertions
	sequence s_fmt5_single;
		frame_valid && link_format_select == FMT_5 && variant == VAR_SINGLE;
	endsequence

	a_fmt5_lane0: assert property (@(posedge ref_clk) disable iff (!nrst)
		s_fmt5_single |=> serial_lane_0[55:48] == FILL_OCTET
			&& serial_lane_0[63:56] == $past(samples[8:1]))
		else $error("format 5 lane 0 wrong");
	a_fmt6_pad: assert property (@(posedge ref_clk) disable iff (!nrst)
		frame_valid && link_format_select == FMT_6 |=> serial_lane_0[54:52] == PAD3)
		else $error("format 6 padding wrong");
	a_fmt6_lane1: assert property (@(posedge ref_clk) disable iff (!nrst)
		frame_valid && link_format_select == FMT_6 && variant == VAR_SINGLE
		|=> serial_lane_1[55:48] == FILL_OCTET && serial_lane_1[58:56] == PAD3)
		else $error("format 6 lane 1 wrong");
	a_fmt7_quiet: assert property (@(posedge ref_clk) disable iff (!nrst)
		frame_valid && link_format_select == FMT_7
		|=> serial_lane_4 == '0 && serial_lane_0[55:0] == '0)
		else $error("format 7 unused bits set");
	a_fmt8_tail: assert property (@(posedge ref_clk) disable iff (!nrst)
		frame_valid && link_format_select == FMT_8
		|=> serial_lane_0[42:40] == PAD3 && serial_lane_0[39:0] == '0)
		else $error("format 8 layout wrong");
	a_fmt9_lanes: assert property (@(posedge ref_clk) disable iff (!nrst)
		frame_valid && link_format_select == FMT_9 && variant == VAR_SINGLE |=> lane_active == 8'h03)
		else $error("format 9 lane count wrong");
	a_fmt10_pad: assert property (@(posedge ref_clk) disable iff (!nrst)
		frame_valid && link_format_select == FMT_10
		|=> serial_lane_0[54] == PAD1 && serial_lane_0[23:0] == '0)
		else $error("format 10 padding wrong");
	a_fmt11_quad: assert property (@(posedge ref_clk) disable iff (!nrst)
		frame_valid && link_format_select == FMT_11 && variant == VAR_QUAD
		|=> lane_active == '0 && serial_lane_0 == '0)
		else $error("format 11 active in quad");
	a_fmt11_tail: assert property (@(posedge ref_clk) disable iff (!nrst)
		frame_valid && link_format_select == FMT_11 && variant == VAR_DUAL
		|=> serial_lane_7[3:0] == $past(tail_fill) && serial_lane_7[6:4] == PAD3)
		else $error("format 11 tail wrong");
	a_valid_follow: assert property (@(posedge ref_clk) disable iff (!nrst)
		frame_valid |=> frame_out_valid ##1 (frame_out_valid == $past(frame_valid)))
		else $error("valid timing wrong");
	a_fmt5_quad: assert property (@(posedge ref_clk) disable iff (!nrst)
		frame_valid && link_format_select == FMT_5 && variant == VAR_QUAD
		|=> serial_lane_1[63:48] == {$past(samples[2*SAMPLES_MAX*SAMPLE_W+1 +: 8]),
			$past(samples[3*SAMPLES_MAX*SAMPLE_W+1 +: 8])})
		else $error("format 5 lane 1 wrong");
	a_fmt6_lane2: assert property (@(posedge ref_clk) disable iff (!nrst)
		frame_valid && link_format_select == FMT_6 && variant == VAR_DUAL
		|=> serial_lane_2[63:60] == {$past(samples[SAMPLES_MAX*SAMPLE_W]), PAD3})
		else $error("format 6 lane 2 wrong");
	a_fmt7_order: assert property (@(posedge ref_clk) disable iff (!nrst)
		frame_valid && link_format_select == FMT_7 && variant == VAR_QUAD
		|=> serial_lane_3[63:56] == $past(samples[3*SAMPLES_MAX*SAMPLE_W+1 +: 8]))
		else $error("format 7 lane 3 wrong");
	a_fmt9_pair: assert property (@(posedge ref_clk) disable iff (!nrst)
		frame_valid && link_format_select == FMT_9 && variant == VAR_QUAD
		|=> serial_lane_7[63:56] == $past(samples[(3*SAMPLES_MAX+1)*SAMPLE_W+1 +: 8]))
		else $error("format 9 lane 7 wrong");
	a_fmt10_odd: assert property (@(posedge ref_clk) disable iff (!nrst)
		frame_valid && link_format_select == FMT_10
		|=> serial_lane_1[53:44] == {$past(samples[3*SAMPLE_W +: SAMPLE_W]), PAD1})
		else $error("format 10 odd lane wrong");
	a_fmt11_lane: assert property (@(posedge ref_clk) disable iff (!nrst)
		frame_valid && link_format_select == FMT_11 && variant == VAR_DUAL
		|=> serial_lane_5[63:52] == {$past(samples[(SAMPLES_MAX+1)*SAMPLE_W +: SAMPLE_W]), PAD3})
		else $error("format 11 lane 5 wrong");
	a_msb_first: assert property (@(posedge ref_clk) disable iff (!nrst)
		frame_valid && link_format_select == FMT_8
		|=> serial_lane_0[63:60] == $past(samples[8:5]))
		else $error("bit order wrong");
endmodule

/* test/lane_rx_model.sv */
// Receiver-side model that collects mapped lane frames
`timescale 1ns/1ps
module lane_rx_model (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic frame_out_valid,
	input wire logic [7:0] lane_active,
	input wire logic [63:0] lane_word,
	output logic [31:0] frames,
	output logic [59:0] last_payload
);
	// ==========================================================
	// Capture
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			frames <= '0;
			last_payload <= '0;
		end else if (frame_out_valid && lane_active[0]) begin
			frames <= frames + 32'h1;
			// Tail nibble dropped, its fill is not data
			last_payload <= lane_word[63:4];
		end
	end
endmodule

/* test/test_lane_sample_mapper.sv */
// Self-checking bench for the lane sample mapper
`timescale 1ns/1ps
module test_lane_sample_mapper;
	import lane_map_pkg::*;
	logic ref_clk = 0, nrst = 0, frame_valid = 0, frame_out_valid;
	logic [3:0] link_format_select = 0, tail_fill = 0, fmt, tl;
	logic [1:0] variant = 0, vs;
	logic [719:0] samples = 0, t;
	logic [7:0] lane_active, m;
	logic [63:0] l0, l1, l2, l3, l4, l5, l6, l7;
	logic [63:0] e [8];
	logic [63:0] lanes [8];
	logic [31:0] frames;
	logic [59:0] payload, pl_exp = '0;
	int errors = 0, num_checks = 0, it, i, sent = 0;
	assign lanes = '{l0, l1, l2, l3, l4, l5, l6, l7};
	always #4 ref_clk = ~ref_clk;
	lane_sample_mapper lane_sample_mapper_i (.ref_clk, .nrst, .link_format_select, .variant,
		.tail_fill, .frame_valid, .samples, .frame_out_valid, .lane_active, .serial_lane_0(l0),
		.serial_lane_1(l1), .serial_lane_2(l2), .serial_lane_3(l3), .serial_lane_4(l4),
		.serial_lane_5(l5), .serial_lane_6(l6), .serial_lane_7(l7));
	lane_rx_model lane_rx_model_i (.ref_clk, .nrst, .frame_out_valid, .lane_active,
		.lane_word(l0), .frames, .last_payload(payload));
	// ==========================================================
	// Reference
	// Channels beyond the variant read as zero, which also gives the 0x00 fills
	function automatic logic [8:0] sv(int c, int n);
		return (c >= (1 << vs)) ? 9'h000 : t[(c * 20 + n) * 9 +: 9];
	endfunction
	function automatic logic [7:0] o8(int c, int n);
		return 8'(sv(c, n) >> 1);
	endfunction
	function automatic logic [11:0] p(logic [8:0] x);
		return {x, PAD3};
	endfunction
	function automatic int nl();
		case (fmt)
			FMT_5: return vs == 2 ? 2 : 1;
			FMT_6: return vs == 0 ? 2 : (vs == 1 ? 3 : 6);
			FMT_7, FMT_8: return 1 << vs;
			FMT_9, FMT_10: return 2 << vs;
			FMT_11: return vs == 2 ? 0 : 4 << vs;
			default: return 0;
		endcase
	endfunction
	function automatic logic [63:0] exp_lane(int l);
		logic [63:0] a;
		logic [47:0] w;
		int n, g, j;
		a = '0;
		n = 64;
		g = l / 3;
		w = {p(sv(2 * g, 0)), p(sv(2 * g, 1)), p(sv(2 * g + 1, 0)), p(sv(2 * g + 1, 1))};
		if (!m[l]) return '0;
		case (fmt)
			FMT_5: begin a = {o8(2 * l, 0), o8(2 * l + 1, 0)}; n = 16; end
			FMT_6: begin a = 64'(w[47 - 16 * (l % 3) -: 16]); n = 16; end
			FMT_7: begin a = o8(l, 0); n = 8; end
			FMT_8: begin a = {p(sv(l, 0)), p(sv(l, 1))}; n = 24; end
			FMT_9: begin a = o8(l / 2, l % 2); n = 8; end
			FMT_10: begin
				for (j = 0; j < 4; j++) a = (a << 10) | {sv(l / 2, l % 2 + 2 * j), PAD1};
				n = 40;
			end
			FMT_11: begin
				for (j = 0; j < 5; j++) a = (a << 12) | p(sv(l / 4, l % 4 + 4 * j));
				a = (a << 4) | tl;
			end
			default: a = '0;
		endcase
		return a << (64 - n);
	endfunction
	// ==========================================================
	// Checking and ending
	task chk(input logic [63:0] g, input logic [63:0] x);
		num_checks++;
		if (g !== x) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	task final_report;
		$display("checks=%0d errors=%0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		#160000;
		errors++;
		final_report;
	end
	// ==========================================================
	// Stimulus: every format and variant first, then random frames
	initial begin
		void'($urandom(30057));
		repeat (8) @(posedge ref_clk);
		chk(lane_active, 0); // Nothing active in reset
		nrst <= 1;
		for (it = 0; it < 120; it++) begin
			@(posedge ref_clk);
			fmt = it < 27 ? 4'(4 + it / 3) : 4'(5 + $urandom % 7);
			vs = it < 27 ? 2'(it % 3) : 2'($urandom % 3);
			tl = it < 27 ? TAIL_DEFAULT : 4'($urandom);
			for (i = 0; i < 720; i += 16) t[i +: 16] = (it % 9 == 4) ? 16'hFFFF : 16'($urandom);
			link_format_select <= fmt;
			variant <= vs;
			tail_fill <= tl;
			samples <= t;
			frame_valid <= 1;
			@(posedge ref_clk);
			frame_valid <= 0;
			#1;
			m = 8'((1 << nl()) - 1);
			chk(frame_out_valid, 1); // One-cycle answer
			chk(lane_active, m);
			for (i = 0; i < 8; i++) begin
				e[i] = exp_lane(i);
				chk(lanes[i], e[i]); // Word
			end
			// Receiver only takes frames that use lane 0
			if (m[0]) begin
				sent++;
				pl_exp = e[0][63:4];
			end
			@(posedge ref_clk);
			samples <= ~t;
			@(posedge ref_clk);
			#1;
			chk(frame_out_valid, 0);
			for (i = 0; i < 8; i++) chk(lanes[i], e[i]); // Held word
		end
		chk(frames, sent);
		chk(payload, pl_exp);
		final_report;
	end
endmodule
